// file: verilog/tws_ctrl.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Operation
// R1: Status field reads 0xF8 whenever the transfer-done flag is clear.
// R2: Start or stop inside a byte or acknowledge reports status 0x00.
// R3: A bus error sets the transfer-done flag.
// R4: Stop request plus done clear after bus error: idle target, stop clears.
// R5: Bus error recovery releases both lines and sends no stop.
// R6: Repeated start keeps bus ownership, direction may change.
// R7: Software does write-then-read with repeated start, not stop.
// R8: Releasing SDA while the bus reads zero loses arbitration.
// R9: Identical traffic from several masters is never seen as contention.
// R10: Arbitration lost in address: check address, enter target mode if hit.
// R11: Lost and not addressed: idle target or start again when bus free.
// R12: Bit rate divisor sets the SCL divider in controller modes.
// R13: Status reads code in bits 7:3, zero bit 2, prescaler bits 1:0.
// R14: Prescaler codes 0 to 3 divide by 1, 4, 16 and 64.
// R15: Software masks prescaler bits when checking status codes.
// R16: Own address bits 7:1 give the answered target address.
// R17: Software loads own address in masters that may be addressed.
// R18: Own address bit 0 enables general call address recognition.
// R19: Address match on own or general call raises the done request.
// R20: Hardware sets done flag; writing one clears it and resumes work.
// R21: While done flag is set, SCL low period is stretched; code releases SCL after bus error, lost arbitration and a stop in target mode.
// R22: SCL period is 16 plus twice divisor times prescaler clocks.
module tws_ctrl
  import tws_pkg::*;
#(
  parameter int APB_AW = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Two-wire bus, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (APB_AW < 12) begin : g_aw_chk
    $error("APB_AW must be at least 12");
  end

  // SDA pull-low flag for a bit slot of the byte frame
  function automatic logic bit_drive(
    input logic [3:0] cnt,
    input logic snd,
    input logic msb,
    input logic ackl
  );
    logic res;
    res = 1'b0;
    if (cnt < 4'd8) begin
      res = snd & ~msb;
    end else if (cnt == 4'd8) begin
      res = ackl;
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  tws_state_t state_r, state_nxt;
  logic master_r, master_nxt;
  logic addressed_r, addressed_nxt;
  logic rx_mode_r, rx_mode_nxt;
  logic addr_ph_r, addr_ph_nxt;
  logic gc_r, gc_nxt;
  logic arb_r, arb_nxt;
  logic rep_r, rep_nxt;
  logic keep_r, keep_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rise_r, rise_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic ackbit_r, ackbit_nxt;
  logic [7:0] status_r, status_nxt;
  logic done_r, done_nxt;
  logic sta_r, sta_nxt;
  logic sto_r, sto_nxt;
  logic acken_r, acken_nxt;
  logic en_r, en_nxt;
  logic [7:0] div_r, div_nxt;
  logic [1:0] presc_r, presc_nxt;
  logic [7:0] own_r, own_nxt;
  logic scl_low_r, scl_low_nxt;
  logic sda_low_r, sda_low_nxt;
  logic [1:0] step_r, step_nxt;
  logic [15:0] hp_cnt_r, hp_nxt;
  logic busy_r;
  logic [31:0] prdata_r;

  // Synchronisers and edge history
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;

  // ------------------------------------------------------------
  // Bus line conditioning
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Edges and bus conditions
  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // Bus busy between a start and a stop
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire [9:0] widx = paddr_i[11:2];
  wire sel_br = (widx == IDX_BIT_RATE);
  wire sel_st = (widx == IDX_STATUS);
  wire sel_own = (widx == IDX_OWN_ADDR);
  wire sel_dat = (widx == IDX_DATA);
  wire sel_ctl = (widx == IDX_CONTROL);
  wire hit_w = sel_br | sel_st | sel_own | sel_dat | sel_ctl;
  wire access_w = psel_i & penable_i;
  wire wr_w = access_w & pwrite_i & hit_w;
  wire wr_br = wr_w & sel_br;
  wire wr_st = wr_w & sel_st;
  wire wr_own = wr_w & sel_own;
  wire wr_dat = wr_w & sel_dat;
  wire wr_ctl = wr_w & sel_ctl;

  // Read sources
  wire [7:0] code_w = done_r ? status_r : SC_NO_INFO; // R1
  wire [7:0] st_rd = {code_w[7:3], 1'b0, presc_r}; // R13
  wire [7:0] ctl_rd = {done_r, acken_r, sta_r, sto_r, 1'b0, en_r, 2'b00};
  wire [7:0] rd_w = sel_br ? div_r :
                    sel_st ? st_rd :
                    sel_own ? own_r :
                    sel_dat ? shift_r :
                    sel_ctl ? ctl_rd : 8'h00;

  // Read data captured in the setup cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel_i & ~penable_i) begin
      prdata_r <= {24'h00_0000, rd_w};
    end
  end

  // Zero wait state, error on unmapped words
  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = access_w & ~hit_w;

  // ------------------------------------------------------------
  // Engine helpers
  // ------------------------------------------------------------
  // Half period: 8 + divisor times prescale
  wire [15:0] hp_lim_w =
    HP_BASE + (16'(div_r) << {presc_r, 1'b0}); // R12 R14 R22
  wire hp_tick = (hp_cnt_r == hp_lim_w - 16'h0001);
  wire snd_w = addr_ph_r ? master_r : ~rx_mode_r;
  wire own_hit = (shift_r[7:1] == own_r[7:1]); // R16
  wire gc_hit = own_r[0] & (shift_r[7:1] == 7'h00); // R18
  wire match_w = acken_r & (own_hit | gc_hit); // R19
  wire ack_low_w = ~snd_w & (addr_ph_r ? match_w : acken_r);
  wire [3:0] cnt_inc = cnt_r + 4'h1;
  wire first_bit = bit_drive(4'h0, snd_w, shift_r[7], ack_low_w);

  // ------------------------------------------------------------
  // Next state of registers and bus engine
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    master_nxt = master_r;
    addressed_nxt = addressed_r;
    rx_mode_nxt = rx_mode_r;
    addr_ph_nxt = addr_ph_r;
    gc_nxt = gc_r;
    arb_nxt = arb_r;
    rep_nxt = rep_r;
    keep_nxt = keep_r;
    cnt_nxt = cnt_r;
    rise_nxt = rise_r;
    shift_nxt = shift_r;
    ackbit_nxt = ackbit_r;
    status_nxt = status_r;
    done_nxt = done_r;
    sta_nxt = sta_r;
    sto_nxt = sto_r;
    acken_nxt = acken_r;
    en_nxt = en_r;
    div_nxt = div_r;
    presc_nxt = presc_r;
    own_nxt = own_r;
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    step_nxt = step_r;
    hp_nxt = hp_cnt_r + 16'h0001;
    // Software writes; hardware below wins on the same cycle
    if (wr_ctl) begin
      if (pwdata_i[CB_DONE]) begin
        done_nxt = 1'b0; // R20
      end
      acken_nxt = pwdata_i[CB_ACK_EN];
      sta_nxt = pwdata_i[CB_START];
      sto_nxt = pwdata_i[CB_STOP];
      en_nxt = pwdata_i[CB_ENABLE];
    end
    if (wr_br) begin
      div_nxt = pwdata_i[7:0];
    end
    if (wr_st) begin
      presc_nxt = pwdata_i[1:0];
    end
    if (wr_own) begin
      own_nxt = pwdata_i[7:0];
    end
    if (wr_dat && done_r) begin
      shift_nxt = pwdata_i[7:0];
    end
    case (state_r)
      S_IDLE: begin
        master_nxt = 1'b0;
        addressed_nxt = 1'b0;
        arb_nxt = 1'b0;
        rep_nxt = 1'b0;
        keep_nxt = 1'b0;
        scl_low_nxt = 1'b0;
        sda_low_nxt = 1'b0;
        hp_nxt = 16'h0000;
        step_nxt = 2'h0;
        if (start_det) begin
          state_nxt = S_XFER;
          addr_ph_nxt = 1'b1;
          cnt_nxt = 4'h0;
          rise_nxt = 1'b0;
        end else if (sta_r && !done_r && !busy_r) begin
          state_nxt = S_START; // R11
          master_nxt = 1'b1;
        end
      end
      S_START: begin
        if (step_r == 2'h0) begin
          sda_low_nxt = 1'b1;
          if (hp_cnt_r == hp_lim_w) begin
            step_nxt = 2'h1;
            hp_nxt = 16'h0000;
            scl_low_nxt = 1'b1;
          end
        end else if (hp_tick) begin
          done_nxt = 1'b1;
          status_nxt = rep_r ? SC_RSTART : SC_START;
          rep_nxt = 1'b0;
          addr_ph_nxt = 1'b1;
          state_nxt = S_HOLD;
        end
      end
      S_RSTART: begin
        if (step_r == 2'h0) begin
          sda_low_nxt = 1'b0;
          if (hp_tick) begin
            step_nxt = 2'h1;
            hp_nxt = 16'h0000;
            scl_low_nxt = 1'b0;
          end
        end else if (!scl_s_r) begin
          hp_nxt = 16'h0000;
        end else if (hp_tick) begin
          state_nxt = S_START; // R6
          step_nxt = 2'h0;
          hp_nxt = 16'h0000;
          rep_nxt = 1'b1;
        end
      end
      S_STOP: begin
        if (step_r == 2'h0) begin
          sda_low_nxt = 1'b1;
          if (hp_tick) begin
            step_nxt = 2'h1;
            hp_nxt = 16'h0000;
            scl_low_nxt = 1'b0;
          end
        end else if (step_r == 2'h1) begin
          if (!scl_s_r) begin
            hp_nxt = 16'h0000;
          end else if (hp_tick) begin
            step_nxt = 2'h2;
            hp_nxt = 16'h0000;
            sda_low_nxt = 1'b0;
          end
        end else if (hp_tick) begin
          state_nxt = S_IDLE;
          sto_nxt = 1'b0;
          master_nxt = 1'b0;
        end
      end
      S_HOLD: begin
        if (!done_r) begin
          hp_nxt = 16'h0000;
          cnt_nxt = 4'h0;
          rise_nxt = 1'b0;
          step_nxt = 2'h0;
          if (status_r == SC_BUS_ERR) begin
            sto_nxt = 1'b0; // R4
            state_nxt = S_IDLE; // R5
          end else if (master_r) begin
            if (sto_r) begin
              state_nxt = S_STOP;
            end else if (sta_r) begin
              state_nxt = S_RSTART; // R6
            end else begin
              state_nxt = S_XFER;
              sda_low_nxt = first_bit;
            end
          end else if (addressed_r && keep_r) begin
            state_nxt = S_XFER;
            sda_low_nxt = first_bit;
          end else begin
            state_nxt = S_IDLE; // R11
            scl_low_nxt = 1'b0;
          end
        end
      end
      S_XFER: begin
        // SCL: controller drives both phases, target only ends stretch
        if (master_r) begin
          if (scl_low_r) begin
            if (hp_tick) begin
              scl_low_nxt = 1'b0;
              hp_nxt = 16'h0000;
            end
          end else if (!scl_s_r) begin
            hp_nxt = 16'h0000;
          end else if (hp_tick) begin
            scl_low_nxt = 1'b1;
            hp_nxt = 16'h0000;
          end
        end else if (scl_low_r && hp_tick) begin
          scl_low_nxt = 1'b0;
        end
        if (start_det || stop_det) begin
          if (cnt_r == 4'h0 && !rise_r) begin
            if (addressed_r) begin
              status_nxt = SC_TR_STOP;
              done_nxt = 1'b1;
              state_nxt = S_HOLD;
              addressed_nxt = 1'b0;
              keep_nxt = 1'b0;
              scl_low_nxt = 1'b0;
              sda_low_nxt = 1'b0;
            end else if (stop_det) begin
              state_nxt = S_IDLE;
            end
          end else begin
            status_nxt = SC_BUS_ERR; // R2
            done_nxt = 1'b1; // R3
            state_nxt = S_HOLD;
            master_nxt = 1'b0;
            addressed_nxt = 1'b0;
            scl_low_nxt = 1'b0; // R5
            sda_low_nxt = 1'b0; // R5
          end
        end else if (scl_rise) begin
          rise_nxt = 1'b1;
          if (cnt_r == 4'h8) begin
            ackbit_nxt = sda_s_r;
          end else begin
            shift_nxt = {shift_r[6:0], sda_s_r};
            if (master_r && snd_w && shift_r[7] && !sda_s_r) begin // R8 R9
              master_nxt = 1'b0;
              arb_nxt = 1'b1;
              scl_low_nxt = 1'b0;
              sda_low_nxt = 1'b0;
              if (!addr_ph_r) begin
                status_nxt = SC_ARB_LOST;
                done_nxt = 1'b1;
                state_nxt = S_HOLD;
              end
            end
          end
        end else if (scl_fall && rise_r) begin
          rise_nxt = 1'b0;
          if (cnt_r != 4'h8) begin
            cnt_nxt = cnt_inc;
            sda_low_nxt = bit_drive(cnt_inc, snd_w, shift_r[7], ack_low_w);
          end else begin
            cnt_nxt = 4'h0;
            sda_low_nxt = 1'b0;
            hp_nxt = 16'h0000;
            addr_ph_nxt = 1'b0;
            done_nxt = 1'b1;
            state_nxt = S_HOLD;
            scl_low_nxt = 1'b1; // R21
            if (master_r) begin
              if (addr_ph_r) begin
                rx_mode_nxt = shift_r[0];
                status_nxt = shift_r[0] ?
                  (ackbit_r ? SC_CR_ADR_NAK : SC_CR_ADR_ACK) :
                  (ackbit_r ? SC_CS_ADR_NAK : SC_CS_ADR_ACK);
              end else if (rx_mode_r) begin
                status_nxt = acken_r ? SC_CR_DAT_ACK : SC_CR_DAT_NAK;
              end else begin
                status_nxt = ackbit_r ? SC_CS_DAT_NAK : SC_CS_DAT_ACK;
              end
            end else if (addr_ph_r) begin
              if (match_w) begin // R10 R19
                addressed_nxt = 1'b1;
                keep_nxt = 1'b1;
                gc_nxt = gc_hit;
                rx_mode_nxt = ~shift_r[0];
                status_nxt = shift_r[0] ?
                  (arb_r ? SC_TS_ARB_ADR : SC_TS_ADR) :
                  gc_hit ? (arb_r ? SC_TR_ARB_GC : SC_TR_GC) :
                  (arb_r ? SC_TR_ARB_ADR : SC_TR_ADR);
              end else begin
                scl_low_nxt = 1'b0;
                if (arb_r) begin
                  status_nxt = SC_ARB_LOST; // R11
                end else begin
                  done_nxt = 1'b0;
                  state_nxt = S_IDLE;
                end
              end
            end else if (rx_mode_r) begin
              keep_nxt = acken_r;
              status_nxt = gc_r ?
                (acken_r ? SC_TR_GC_ACK : SC_TR_GC_NAK) :
                (acken_r ? SC_TR_DAT_ACK : SC_TR_DAT_NAK);
            end else begin
              keep_nxt = ~ackbit_r;
              status_nxt = ackbit_r ? SC_TS_DAT_NAK : SC_TS_DAT_ACK;
            end
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    // Interface off: release everything
    if (!en_r) begin
      state_nxt = S_IDLE;
      master_nxt = 1'b0;
      addressed_nxt = 1'b0;
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Software visible registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      acken_r <= 1'b0;
      en_r <= 1'b0;
      div_r <= RST_BIT_RATE;
      presc_r <= RST_PRESC;
      own_r <= RST_OWN_ADDR;
      shift_r <= RST_DATA;
      status_r <= SC_NO_INFO;
    end else begin
      done_r <= done_nxt;
      sta_r <= sta_nxt;
      sto_r <= sto_nxt;
      acken_r <= acken_nxt;
      en_r <= en_nxt;
      div_r <= div_nxt;
      presc_r <= presc_nxt;
      own_r <= own_nxt;
      shift_r <= shift_nxt;
      status_r <= status_nxt;
    end
  end

  // Engine registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= S_IDLE;
      master_r <= 1'b0;
      addressed_r <= 1'b0;
      rx_mode_r <= 1'b0;
      addr_ph_r <= 1'b0;
      gc_r <= 1'b0;
      arb_r <= 1'b0;
      rep_r <= 1'b0;
      keep_r <= 1'b0;
      cnt_r <= 4'h0;
      rise_r <= 1'b0;
      ackbit_r <= 1'b1;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      step_r <= 2'h0;
      hp_cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      master_r <= master_nxt;
      addressed_r <= addressed_nxt;
      rx_mode_r <= rx_mode_nxt;
      addr_ph_r <= addr_ph_nxt;
      gc_r <= gc_nxt;
      arb_r <= arb_nxt;
      rep_r <= rep_nxt;
      keep_r <= keep_nxt;
      cnt_r <= cnt_nxt;
      rise_r <= rise_nxt;
      ackbit_r <= ackbit_nxt;
      scl_low_r <= scl_low_nxt;
      sda_low_r <= sda_low_nxt;
      step_r <= step_nxt;
      hp_cnt_r <= hp_nxt;
    end
  end

  // Open-drain pins: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = ~scl_low_r;
  assign sda_oe_n_o = ~sda_low_r;

endmodule
`default_nettype wire

// file: verilog/tws_pkg.sv
`default_nettype none
package tws_pkg;

  // ------------------------------------------------------------
  // Register map: printed indices, byte address is index times 4
  // ------------------------------------------------------------
  localparam logic [9:0] IDX_BIT_RATE = 10'h0B8;
  localparam logic [9:0] IDX_STATUS = 10'h0B9;
  localparam logic [9:0] IDX_OWN_ADDR = 10'h0BA;
  localparam logic [9:0] IDX_DATA = 10'h0BB;
  localparam logic [9:0] IDX_CONTROL = 10'h0BC;

  // Reset values
  localparam logic [7:0] RST_BIT_RATE = 8'h00;
  localparam logic [1:0] RST_PRESC = 2'h0;
  localparam logic [7:0] RST_OWN_ADDR = 8'hFE;
  localparam logic [7:0] RST_DATA = 8'hFF;

  // Control register bit positions
  localparam int CB_DONE = 7;
  localparam int CB_ACK_EN = 6;
  localparam int CB_START = 5;
  localparam int CB_STOP = 4;
  localparam int CB_ENABLE = 2;

  // Half of the fixed part of the SCL period, in clocks
  localparam logic [15:0] HP_BASE = 16'h0008;

  // ------------------------------------------------------------
  // Status codes (prescaler bits masked to zero)
  // ------------------------------------------------------------
  localparam logic [7:0] SC_NO_INFO = 8'hF8;
  localparam logic [7:0] SC_BUS_ERR = 8'h00;
  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RSTART = 8'h10;
  localparam logic [7:0] SC_CS_ADR_ACK = 8'h18;
  localparam logic [7:0] SC_CS_ADR_NAK = 8'h20;
  localparam logic [7:0] SC_CS_DAT_ACK = 8'h28;
  localparam logic [7:0] SC_CS_DAT_NAK = 8'h30;
  localparam logic [7:0] SC_ARB_LOST = 8'h38;
  localparam logic [7:0] SC_CR_ADR_ACK = 8'h40;
  localparam logic [7:0] SC_CR_ADR_NAK = 8'h48;
  localparam logic [7:0] SC_CR_DAT_ACK = 8'h50;
  localparam logic [7:0] SC_CR_DAT_NAK = 8'h58;
  localparam logic [7:0] SC_TR_ADR = 8'h60;
  localparam logic [7:0] SC_TR_ARB_ADR = 8'h68;
  localparam logic [7:0] SC_TR_GC = 8'h70;
  localparam logic [7:0] SC_TR_ARB_GC = 8'h78;
  localparam logic [7:0] SC_TR_DAT_ACK = 8'h80;
  localparam logic [7:0] SC_TR_DAT_NAK = 8'h88;
  localparam logic [7:0] SC_TR_GC_ACK = 8'h90;
  localparam logic [7:0] SC_TR_GC_NAK = 8'h98;
  localparam logic [7:0] SC_TR_STOP = 8'hA0;
  localparam logic [7:0] SC_TS_ADR = 8'hA8;
  localparam logic [7:0] SC_TS_ARB_ADR = 8'hB0;
  localparam logic [7:0] SC_TS_DAT_ACK = 8'hB8;
  localparam logic [7:0] SC_TS_DAT_NAK = 8'hC0;

  // Engine states
  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_RSTART,
    S_XFER,
    S_HOLD,
    S_STOP
  } tws_state_t;

endpackage
`default_nettype wire

// file: tb/tws_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module tws_ctrl_sva
  import tws_pkg::*;
#(
  parameter int APB_AW = 12
) (
  // APB side
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Two-wire lines
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o
);
  // ----------------
  // Decode and steps
  // ----------------
  wire logic [9:0] idx_w = paddr_i[11:2];
  wire logic map_w = (idx_w >= IDX_BIT_RATE) && (idx_w <= IDX_CONTROL);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_acc; psel_i && penable_i; endsequence
  sequence s_rd; s_acc ##0 !pwrite_i; endsequence
  sequence s_start; $fell(sda_oe_n_o) && scl_i && scl_oe_n_o; endsequence
  sequence s_off;
    s_acc ##0 (pwrite_i && idx_w == IDX_CONTROL && !pwdata_i[CB_ENABLE]);
  endsequence
  AST_READY_CONST: assert property (pready_o)
    else $error("pready low");
  AST_SLVERR_MAP: assert property (s_acc |-> pslverr_o == !map_w)
    else $error("bad slverr");
  AST_UNMAPPED_ZERO: assert property (s_rd ##0 !map_w |-> prdata_o == 32'h0)
    else $error("unmapped data");
  AST_STATUS_BITS: assert property (s_rd ##0 idx_w == IDX_STATUS |->
    prdata_o[2] == 1'h0 && prdata_o[31:8] == 24'h0)
    else $error("status bits");
  AST_OPEN_DRAIN: assert property (scl_o == 1'h0 && sda_o == 1'h0)
    else $error("line value");
  AST_START_HOLD: assert property (s_start |-> scl_oe_n_o[*8])
    else $error("start hold");
  AST_HIGH_MIN: assert property ($rose(scl_oe_n_o) |-> scl_oe_n_o[*8])
    else $error("clock high");
  AST_OFF_RELEASE: assert property (s_off |-> ##[1:3]
    (scl_oe_n_o && sda_oe_n_o))
    else $error("lines held");
endmodule
`default_nettype wire

// file: tb/tws_peer.sv
`timescale 1ns/10ps
`default_nettype none
module tws_peer #(
  parameter int HP = 40
) (
  // Clock and line levels
  input wire logic mclk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  // Open-drain enables
  output logic scl_oe_n_o = 1'h1,
  output logic sda_oe_n_o = 1'h1
);
  // --------------
  // Bus conditions
  // --------------
  // One bit, waits out stretching
  task automatic put_bit(input logic b, output logic smp);
    repeat (HP / 2) @(posedge mclk_i);
    sda_oe_n_o <= b;
    repeat (HP) @(posedge mclk_i);
    scl_oe_n_o <= 1'h1;
    @(posedge mclk_i);
    while (scl_i !== 1'h1) @(posedge mclk_i);
    repeat (HP) @(posedge mclk_i);
    smp = sda_i;
    scl_oe_n_o <= 1'h0;
  endtask
  // SDA falls while SCL high
  task automatic start_cond();
    sda_oe_n_o <= 1'h0;
    repeat (HP) @(posedge mclk_i);
    scl_oe_n_o <= 1'h0;
  endtask
  // MSB first, ack only after a whole byte
  task automatic send(input logic [7:0] b, input int nb, output logic ak);
    logic s;
    for (int i = 7; i > 7 - nb; i--) put_bit(b[i], s);
    if (nb == 8) put_bit(1'h1, ak);
  endtask
  // SDA rises while SCL high
  task automatic stop_cond();
    repeat (HP / 2) @(posedge mclk_i);
    sda_oe_n_o <= 1'h0;
    repeat (HP) @(posedge mclk_i);
    scl_oe_n_o <= 1'h1;
    repeat (HP) @(posedge mclk_i);
    sda_oe_n_o <= 1'h1;
    repeat (HP) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tws_pkg::*;
  // ---------------
  // Signals, models
  // ---------------
  logic mclk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] rv;
  logic err, ack;
  wire logic [31:0] prdata_o;
  wire logic pready_o, pslverr_o, scl_o, sda_o;
  wire logic scl_oe_n_o, sda_oe_n_o, p_scl_n, p_sda_n;
  wire logic scl_w = scl_oe_n_o & p_scl_n;
  wire logic sda_w = sda_oe_n_o & p_sda_n;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #5 mclk_i = ~mclk_i;
  tws_ctrl dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o));
  tws_peer #(.HP(40)) peer (.mclk_i(mclk_i), .scl_i(scl_w), .sda_i(sda_w),
    .scl_oe_n_o(p_scl_n), .sda_oe_n_o(p_sda_n));
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= {ix, 2'h0};
    pwdata_i <= {24'h0, d};
    @(posedge mclk_i);
    penable_i <= 1'h1;
    @(posedge mclk_i);
    while (pready_o !== 1'h1) @(posedge mclk_i);
    rv = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge mclk_i);
  endtask
  task automatic rchk(input string nm, input logic [9:0] ix,
    input logic [31:0] m, e);
    apb(1'h0, ix, 8'h00);
    chk(nm, rv & m, e);
  endtask
  // Start, repeated start, stop
  task automatic start_stop(input int p);
    apb(1'h1, IDX_STATUS, 8'(p));
    rchk("status", IDX_STATUS, 32'hFF, {24'h0, SC_NO_INFO | 8'(p)});
    apb(1'h1, IDX_CONTROL, 8'hA4);
    n = 0;
    while (sda_oe_n_o !== 1'h0) @(posedge mclk_i);
    while (scl_oe_n_o !== 1'h0) begin
      @(posedge mclk_i);
      n++;
    end
    chk("half period", 32'(n), 32'(8 + 2 * (1 << (2 * p))));
    do apb(1'h0, IDX_CONTROL, 8'h00); while (rv[7] !== 1'h1);
    rchk("status", IDX_STATUS, 32'hF8, {24'h0, SC_START});
    apb(1'h1, IDX_CONTROL, 8'hA4);
    do apb(1'h0, IDX_CONTROL, 8'h00); while (rv[7] !== 1'h1);
    rchk("status", IDX_STATUS, 32'hF8, {24'h0, SC_RSTART});
    apb(1'h1, IDX_CONTROL, 8'h94);
    do apb(1'h0, IDX_CONTROL, 8'h00); while (rv[4] !== 1'h0);
    rchk("status", IDX_STATUS, 32'hF8, {24'h0, SC_NO_INFO});
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'h1;
    @(posedge mclk_i);
    rchk("bit rate", IDX_BIT_RATE, 32'hFFFFFFFF, 32'h00);
    rchk("status", IDX_STATUS, 32'hFFFFFFFF, 32'hF8);
    rchk("own addr", IDX_OWN_ADDR, 32'hFFFFFFFF, 32'hFE);
    apb(1'h0, 10'h000, 8'h00);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'h1, IDX_BIT_RATE, 8'h02);
    rchk("bit rate", IDX_BIT_RATE, 32'hFF, 32'h02);
    for (int p = 0; p < 4; p++) start_stop(p);
    apb(1'h1, IDX_OWN_ADDR, 8'hA4);
    rchk("own addr", IDX_OWN_ADDR, 32'hFF, 32'hA4);
    apb(1'h1, IDX_CONTROL, 8'h44);
    peer.start_cond();
    peer.send(8'hA4, 8, ack);
    chk("ack", {31'h0, ack}, 32'h0);
    repeat (4) @(posedge mclk_i);
    rchk("status", IDX_STATUS, 32'hF8, {24'h0, SC_TR_ADR});
    apb(1'h1, IDX_CONTROL, 8'hC4);
    peer.send(8'hA0, 3, ack);
    peer.stop_cond();
    rchk("status", IDX_STATUS, 32'hF8, {24'h0, SC_BUS_ERR});
    rchk("control", IDX_CONTROL, 32'hFF, 32'hC4);
    apb(1'h1, IDX_CONTROL, 8'hD4);
    rchk("control", IDX_CONTROL, 32'hFF, 32'h44);
    rchk("status", IDX_STATUS, 32'hF8, {24'h0, SC_NO_INFO});
    repeat (30) @(posedge mclk_i);
    chk("lines", {30'h0, scl_oe_n_o, sda_oe_n_o}, 32'h3);
    apb(1'h1, IDX_CONTROL, 8'h00);
    tally_and_finish();
  end
endmodule
bind tws_ctrl tws_ctrl_sva #(.APB_AW(APB_AW)) u_sva (.mclk_i(mclk_i),
  .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
`default_nettype wire
